// *** rtl/lsl_regs.vh ***
// Purpose: register map and constants of the line stamp / lookup block
// Assumes: 32-bit APB, word aligned registers
// Notes:   definitions only
`ifndef LSL_REGS_VH
`define LSL_REGS_VH

// register byte offsets
`define LSL_ADDR_CTRL   12'h000
`define LSL_ADDR_LOW    12'h004
`define LSL_ADDR_HIGH   12'h008
`define LSL_ADDR_LIDX   12'h00C
`define LSL_ADDR_LVAL   12'h010
`define LSL_ADDR_STAT   12'h014

// control fields
`define LSL_CTRL_STAMP  0
`define LSL_CTRL_LUT    1
`define LSL_CTRL_MODE_L 2
`define LSL_CTRL_MODE_H 3
`define LSL_CTRL_DUAL   4
`define LSL_CTRL_W      5

// output modes
`define LSL_MODE_8      2'h0
`define LSL_MODE_10     2'h1

// reset values
`define LSL_CTRL_RST    5'h00
`define LSL_LOW_RST     12'h000
`define LSL_HIGH_RST    12'hFFF
`define LSL_LIDX_RST    13'h0000
`define LSL_CNT_RST     16'h0000

// stamp contents
`define LSL_MARK_FIRST  8'hAA
`define LSL_MARK_A      8'h55
`define LSL_MARK_B      8'h57
`define LSL_RSVD        8'h00
`define LSL_STAMP_LAST  4'hF

// lookup table
`define LSL_LUT_TOP     11'h400

`endif

// *** rtl/lsl_top.v ***
// Purpose: line stamp generator and 12-to-8 bit lookup conversion
// Assumes: pixel stream on pclk, one pixel per cycle when accepted
// Notes:   registers over APB, zero wait states
//
// What this block does
// - first stamp pixel is always the marker 0xAA
// - second stamp pixel is 0x57 for dual mode line B, else 0x55
// - 16-bit line counter from zero, plus one per line, wraps
// - line counter cleared on reset and while stamping is off
// - stamp pixels five to seven carry the 24-bit line sum
// - statistics use region pixels only, never the stamp pixels
// - stamp pixels eight and sixteen are always zero
// - count pixels strictly above high threshold, stamps nine and ten
// - count pixels strictly below low limit, stamps eleven and twelve
// - contrast is sum of neighbour absolute differences, stamps 13-15
// - with stamping on, sixteen stamp pixels follow every line
// - wide modes carry stamp byte in top 8 bits, low bits zero
// - stamps follow last region pixel at once, valids stay high
// - stamp enable, low limit and high threshold are software fields
// - 8-bit mode without table drops the 4 low sensor bits
// - table of 1025 writable bytes at indices 0,4,...,4096
// - exact index gives entry, other values interpolate linearly
// - entry 4096 only serves as upper point for 4093..4095
// - table result in wide modes sits in top bits, zeros below
// - table value write lands at the index written before
// - table applies only while its LUT control bit enables it
//
// Chosen here: the APB register port and the register addresses.
`include "lsl_regs.vh"
`timescale 1ns/10ps
`default_nettype none

module lsl_top #(
  parameter PW = 12,
  parameter LUT_N = 1025
) (
  // apb slave
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // sensor pixel stream
  input  wire          pix_valid,
  input  wire [PW-1:0] pix_data,
  input  wire          pix_last,
  input  wire          pix_line_b,
  output reg           pix_ready,
  // line stream to grabber
  output reg           vid_lval,
  output reg           vid_dval,
  output reg  [PW-1:0] vid_data
);

  localparam ST_LINE  = 1'b0;
  localparam ST_STAMP = 1'b1;

  // control registers
  reg [`LSL_CTRL_W-1:0] ctrl_q;
  reg [PW-1:0]          low_q;
  reg [PW-1:0]          high_q;
  reg [12:0]            lidx_q;
  reg [7:0]             lut_mem [0:LUT_N-1];

  wire       stamp_en = ctrl_q[`LSL_CTRL_STAMP];
  wire       lut_en   = ctrl_q[`LSL_CTRL_LUT];
  wire [1:0] omode    = ctrl_q[`LSL_CTRL_MODE_H:`LSL_CTRL_MODE_L];
  wire       dual     = ctrl_q[`LSL_CTRL_DUAL];

  // line statistics
  reg  [15:0]   lcnt_q;
  wire [23:0]   sum_q;
  wire [23:0]   sum_d;
  wire [23:0]   con_q;
  wire [23:0]   con_d;
  wire [15:0]   hi_q;
  wire [15:0]   hi_d;
  wire [15:0]   lo_q;
  wire [15:0]   lo_d;
  reg  [PW-1:0] prev_q;
  reg           first_q;

  // latched stamp of the finished line
  reg [15:0] s_cnt_q;
  reg [23:0] s_sum_q;
  reg [23:0] s_con_q;
  reg [15:0] s_hi_q;
  reg [15:0] s_lo_q;
  reg        s_b_q;

  reg        state_q;
  reg [3:0]  pos_q;

  // apb decode
  wire setup  = psel & ~penable;
  wire access = psel & penable & pready;
  wire wr     = access & pwrite;
  // indices past the top entry are neither written nor read
  wire lidx_ok = (lidx_q[12:2] <= `LSL_LUT_TOP);

  reg        hit;
  reg [31:0] rd;
  always @* begin
    hit = 1'b1;
    rd  = 32'h0000_0000;
    case (paddr)
      `LSL_ADDR_CTRL: rd[`LSL_CTRL_W-1:0] = ctrl_q;
      `LSL_ADDR_LOW:  rd[PW-1:0] = low_q;
      `LSL_ADDR_HIGH: rd[PW-1:0] = high_q;
      `LSL_ADDR_LIDX: rd[12:0] = lidx_q;
      `LSL_ADDR_LVAL: begin
        if (lidx_ok) begin
          rd[7:0] = lut_mem[lidx_q[12:2]];
        end
      end
      `LSL_ADDR_STAT: rd[15:0] = lcnt_q;
      default: hit = 1'b0;
    endcase
  end

  // answer is prepared in the setup cycle, so access never waits
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= setup;
      pslverr <= setup & ~hit;
      // writes return zero, so a refused write never shows stale data
      if (setup) begin
        prdata <= pwrite ? 32'h0000_0000 : rd;
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= `LSL_CTRL_RST;
      low_q  <= `LSL_LOW_RST;
      high_q <= `LSL_HIGH_RST;
      lidx_q <= `LSL_LIDX_RST;
    end else if (wr) begin
      case (paddr)
        `LSL_ADDR_CTRL: ctrl_q <= pwdata[`LSL_CTRL_W-1:0];
        `LSL_ADDR_LOW:  low_q  <= pwdata[PW-1:0];
        `LSL_ADDR_HIGH: high_q <= pwdata[PW-1:0];
        `LSL_ADDR_LIDX: lidx_q <= pwdata[12:0];
        default: ;
      endcase
    end
  end

  // table has no reset; software loads it before enabling
  wire lut_wr = wr & (paddr == `LSL_ADDR_LVAL) & lidx_ok;
  always @(posedge pclk) begin
    if (lut_wr) begin
      lut_mem[lidx_q[12:2]] <= pwdata[7:0];
    end
  end

  // lookup with interpolation
  wire [10:0] li     = {1'b0, pix_data[11:2]};
  wire [10:0] li_nx  = li + 11'h001;
  wire [7:0]  e_lo   = lut_mem[li];
  wire [7:0]  e_hi   = lut_mem[li_nx];
  wire [1:0]  off    = pix_data[1:0];
  wire signed [8:0]  dif  = $signed({1'b0, e_hi}) - $signed({1'b0, e_lo});
  wire signed [11:0] prod = dif * $signed({1'b0, off});
  // bias negative products so the shift truncates toward zero
  wire signed [11:0] bias = prod + (prod[11] ? 12'sh003 : 12'sh000);
  wire signed [11:0] step = bias >>> 2;
  wire [11:0] lsum  = {4'h0, e_lo} + step;
  wire [7:0]  lres  = (off == 2'h0) ? e_lo : lsum[7:0];

  // an 8-bit value in the top bits of the active output width
  function [PW-1:0] place;
    input [1:0] m;
    input [7:0] b;
    begin
      place = {PW{1'b0}};
      if (m == `LSL_MODE_8) begin
        place[7:0] = b;
      end else if (m == `LSL_MODE_10) begin
        place[9:0] = {b, 2'b00};
      end else begin
        place = {b, 4'h0};
      end
    end
  endfunction

  reg [PW-1:0] pix_out;
  always @* begin
    if (lut_en) begin
      pix_out = place(omode, lres);
    end else if (omode == `LSL_MODE_8) begin
      pix_out = {4'h0, pix_data[11:4]};
    end else if (omode == `LSL_MODE_10) begin
      pix_out = {2'b00, pix_data[11:2]};
    end else begin
      pix_out = pix_data;
    end
  end

  // statistic updates for the pixel now accepted
  wire take = pix_valid & pix_ready;
  wire [PW-1:0] adiff = (pix_data > prev_q) ? pix_data - prev_q :
                                              prev_q - pix_data;
  wire [23:0] con_inc = first_q ? 24'h00_0000 : {12'h000, adiff};

  // only accepted region pixels touch the accumulators
  lsl_accum #(.W(24)) sum_u (
    .pclk    (pclk),
    .presetn (presetn),
    .take    (take),
    .last    (pix_last),
    .inc     ({12'h000, pix_data}),
    .acc_q   (sum_q),
    .acc_d   (sum_d)
  );

  lsl_accum #(.W(24)) con_u (
    .pclk    (pclk),
    .presetn (presetn),
    .take    (take),
    .last    (pix_last),
    .inc     (con_inc),
    .acc_q   (con_q),
    .acc_d   (con_d)
  );

  lsl_accum #(.W(16)) hi_u (
    .pclk    (pclk),
    .presetn (presetn),
    .take    (take),
    .last    (pix_last),
    .inc     ((pix_data > high_q) ? 16'h0001 : 16'h0000),
    .acc_q   (hi_q),
    .acc_d   (hi_d)
  );

  lsl_accum #(.W(16)) lo_u (
    .pclk    (pclk),
    .presetn (presetn),
    .take    (take),
    .last    (pix_last),
    .inc     ((pix_data < low_q) ? 16'h0001 : 16'h0000),
    .acc_q   (lo_q),
    .acc_d   (lo_d)
  );

  // first pixel of a line has no neighbour for the contrast
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_q  <= {PW{1'b0}};
      first_q <= 1'b1;
    end else if (take) begin
      first_q <= pix_last;
      prev_q  <= pix_data;
    end
  end

  // line counter
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lcnt_q <= `LSL_CNT_RST;
    end else if (!stamp_en) begin
      lcnt_q <= `LSL_CNT_RST;
    end else if (take && pix_last) begin
      lcnt_q <= lcnt_q + 16'h0001;
    end
  end

  // snapshot taken with the last pixel folded in
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_cnt_q <= 16'h0000;
      s_sum_q <= 24'h00_0000;
      s_con_q <= 24'h00_0000;
      s_hi_q  <= 16'h0000;
      s_lo_q  <= 16'h0000;
      s_b_q   <= 1'b0;
    end else if (take && pix_last) begin
      s_cnt_q <= lcnt_q;
      s_sum_q <= sum_d;
      s_con_q <= con_d;
      s_hi_q  <= hi_d;
      s_lo_q  <= lo_d;
      s_b_q   <= dual & pix_line_b;
    end
  end

  // stamp byte by position
  reg [7:0] sbyte;
  always @* begin
    case (pos_q)
      4'h0: sbyte = `LSL_MARK_FIRST;
      4'h1: sbyte = s_b_q ? `LSL_MARK_B : `LSL_MARK_A;
      4'h2: sbyte = s_cnt_q[7:0];
      4'h3: sbyte = s_cnt_q[15:8];
      4'h4: sbyte = s_sum_q[7:0];
      4'h5: sbyte = s_sum_q[15:8];
      4'h6: sbyte = s_sum_q[23:16];
      4'h8: sbyte = s_hi_q[7:0];
      4'h9: sbyte = s_hi_q[15:8];
      4'hA: sbyte = s_lo_q[7:0];
      4'hB: sbyte = s_lo_q[15:8];
      4'hC: sbyte = s_con_q[7:0];
      4'hD: sbyte = s_con_q[15:8];
      4'hE: sbyte = s_con_q[23:16];
      default: sbyte = `LSL_RSVD;
    endcase
  end

  // output sequencer; input stalls while the stamp is sent
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q   <= ST_LINE;
      pos_q     <= 4'h0;
      pix_ready <= 1'b0;
      vid_lval  <= 1'b0;
      vid_dval  <= 1'b0;
      vid_data  <= {PW{1'b0}};
    end else begin
      case (state_q)
        ST_LINE: begin
          pix_ready <= 1'b1;
          vid_lval  <= take;
          vid_dval  <= take;
          vid_data  <= take ? pix_out : {PW{1'b0}};
          pos_q     <= 4'h0;
          if (take && pix_last && stamp_en) begin
            state_q   <= ST_STAMP;
            pix_ready <= 1'b0;
          end
        end
        ST_STAMP: begin
          vid_lval <= 1'b1;
          vid_dval <= 1'b1;
          vid_data <= place(omode, sbyte);
          pos_q    <= pos_q + 4'h1;
          if (pos_q == `LSL_STAMP_LAST) begin
            state_q   <= ST_LINE;
            pix_ready <= 1'b1;
          end
        end
        default: begin
          state_q   <= ST_LINE;
          pix_ready <= 1'b0;
        end
      endcase
    end
  end

endmodule // lsl_top

module lsl_accum #(
  parameter W = 24
) (
  // clock and reset
  input  wire         pclk,
  input  wire         presetn,
  // update control
  input  wire         take,
  input  wire         last,
  input  wire [W-1:0] inc,
  // running total, and total with this input folded in
  output reg  [W-1:0] acc_q,
  output wire [W-1:0] acc_d
);

  // wraps silently, only the low bits are kept
  assign acc_d = acc_q + inc;

  // a line end restarts the total for the next line
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_q <= {W{1'b0}};
    end else if (take) begin
      if (last) begin
        acc_q <= {W{1'b0}};
      end else begin
        acc_q <= acc_d;
      end
    end
  end

endmodule // lsl_accum

`default_nettype wire

// *** verification/lsl_asserts.sv ***
// Purpose: port checks of lsl_top
// Assumes: zero wait apb, 16 stamps per line
// Notes:   stamp enable is internal, so checks key on pix_ready falling
`timescale 1ns/10ps
`default_nettype none
module lsl_asserts #(parameter PW = 12) (
  // apb
  input wire logic          pclk,
  input wire logic          presetn,
  input wire logic          psel,
  input wire logic          penable,
  input wire logic [31:0]   prdata,
  input wire logic          pready,
  input wire logic          pslverr,
  // stream
  input wire logic          pix_valid,
  input wire logic          pix_ready,
  input wire logic          vid_lval,
  input wire logic          vid_dval,
  input wire logic [PW-1:0] vid_data
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // any of the three mode placements of a stamp byte
  function automatic logic is_b(logic [PW-1:0] v, logic [7:0] b);
    return v == {4'h0, b} || v == {2'h0, b, 2'h0} || v == {b, 4'h0};
  endfunction
  sequence s_start;
    $fell(pix_ready);
  endsequence
  sequence s_marks;
    vid_dval && is_b(vid_data, 8'hAA) ##1
    vid_dval && (is_b(vid_data, 8'h55) || is_b(vid_data, 8'h57));
  endsequence
  sequence s_zero;
    vid_dval && vid_data == 12'h000;
  endsequence
  a_apb_ready: assert property (psel && !penable |=> pready)
    else $error("pready missing in access cycle");
  a_apb_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_err_ready: assert property (pslverr |-> pready && prdata == 0)
    else $error("error without ready or with data");
  a_pix_echo: assert property (pix_valid && pix_ready |=> vid_dval)
    else $error("accepted pixel not sent next cycle");
  a_stamp_head: assert property (s_start |=> s_marks)
    else $error("stamp markers wrong");
  a_rsvd_zero: assert property (s_start |-> ##8 s_zero ##8 s_zero)
    else $error("reserved stamp not zero");
  a_refuse_span: assert property (s_start |->
    !pix_ready[*8] ##1 !pix_ready[*8] ##1 pix_ready)
    else $error("pix_ready low span not sixteen");
  a_valid_span: assert property (s_start |=>
    (vid_lval && vid_dval)[*8] ##1 (vid_lval && vid_dval)[*8])
    else $error("valids dropped during stamps");
endmodule // lsl_asserts
bind lsl_top lsl_asserts #(.PW(PW)) chk_u (.pclk, .presetn, .psel,
  .penable, .prdata, .pready, .pslverr, .pix_valid, .pix_ready,
  .vid_lval, .vid_dval, .vid_data);
`default_nettype wire

// *** verification/lsl_grabber.sv ***
// Purpose: grabber model, keeps every valid output value
// Assumes: one value per dval cycle
// Notes:   bench empties q after each line
`timescale 1ns/10ps
`default_nettype none
module lsl_grabber #(parameter PW = 12) (
  // video in
  input wire logic          pclk,
  input wire logic          vid_lval,
  input wire logic          vid_dval,
  input wire logic [PW-1:0] vid_data
);
  logic [PW-1:0] q[$];
  always @(posedge pclk) begin
    if (vid_lval && vid_dval) begin
      q.push_back(vid_data);
    end
  end
endmodule // lsl_grabber
`default_nettype wire

// *** verification/lsl_top_tb.sv ***
// Purpose: bench of lsl_top, registers, table and stamped lines
// Assumes: zero wait apb, grabber model collects output
// Notes:   counter wrap at 65535 not run, far too long
`include "lsl_regs.vh"
`timescale 1ns/10ps
`default_nettype none
module lsl_top_tb;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        pix_valid, pix_last, pix_line_b, pix_ready, err;
  logic        vid_lval, vid_dval;
  logic [11:0] paddr, pix_data, vid_data, lo, hi;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] lines;
  logic [4:0]  ctrl;
  logic [7:0]  lut[0:1024];
  logic [11:0] px[$], ex[$];
  int          miscompares, total_checks;
  int          ix[6] = '{0, 4, 8, 12, 4092, 4096};
  int          vx[6] = '{90, 20, 10, 30, 100, 200};
  lsl_top dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .pix_valid, .pix_data,
    .pix_last, .pix_line_b, .pix_ready, .vid_lval, .vid_dval, .vid_data);
  lsl_grabber gr_u (.pclk, .vid_lval, .vid_dval, .vid_data);
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(logic [31:0] g, logic [31:0] w, string m);
    total_checks++;
    if (g !== w) begin
      miscompares++;
      $display("unexpected at %0t: %s got %h want %h", $time, m, g, w);
    end
  endtask
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    // one idle edge, so a following call never drives psel twice at once
    @(posedge pclk);
  endtask
  task automatic set(logic [4:0] v);
    ctrl = v;
    apb(1, `LSL_ADDR_CTRL, v);
  endtask
  function automatic logic [11:0] place(logic [7:0] v);
    return ctrl[3:2] == 0 ? {4'h0, v} :
           ctrl[3:2] == 1 ? {2'h0, v, 2'h0} : {v, 4'h0};
  endfunction
  function automatic logic [11:0] conv(logic [11:0] p);
    int a, b, o;
    a = lut[p >> 2];
    b = lut[(p >> 2) + 1];
    o = p[1:0];
    // signed int math so a falling step rounds toward zero
    if (ctrl[1]) return place(a + (b - a) * o / 4);
    return ctrl[3:2] == 0 ? p >> 4 : ctrl[3:2] == 1 ? p >> 2 : p;
  endfunction
  task automatic line(logic b);
    logic [23:0] s, c;
    logic [15:0] h, l;
    logic [7:0]  st[16];
    {s, c, h, l} = 0;
    ex = {};
    foreach (px[i]) begin
      s += px[i];
      if (i > 0) c += px[i] > px[i-1] ? px[i] - px[i-1] : px[i-1] - px[i];
      h += px[i] > hi;
      l += px[i] < lo;
      ex.push_back(conv(px[i]));
    end
    st = '{8'hAA, b && ctrl[4] ? 8'h57 : 8'h55, lines[7:0], lines[15:8],
      s[7:0], s[15:8], s[23:16], 0, h[7:0], h[15:8], l[7:0], l[15:8],
      c[7:0], c[15:8], c[23:16], 0};
    if (ctrl[0]) foreach (st[i]) ex.push_back(place(st[i]));
    foreach (px[i]) begin
      pix_valid <= 1;
      pix_data <= px[i];
      pix_last <= i == px.size() - 1;
      pix_line_b <= b;
      do @(posedge pclk); while (pix_ready !== 1'b1);
    end
    pix_valid <= 0;
    pix_last <= 0;
    repeat (20) @(posedge pclk);
    chk(gr_u.q.size(), ex.size(), "line length");
    foreach (ex[i]) chk(gr_u.q[i], ex[i], "value");
    gr_u.q = {};
    if (ctrl[0]) lines++;
    $display("line done, %0d values", ex.size());
  endtask
  initial begin
    pclk = 0;
    forever #12.5 pclk = ~pclk;
  end
  // a run takes about 210 cycles, limit is 16000 cycles, over seventy times that
  initial begin
    #400us;
    miscompares++;
    conclude();
  end
  initial begin
    {psel, penable, pwrite, pix_valid, pix_last, pix_line_b} = 0;
    {paddr, pix_data, pwdata, presetn, lines} = 0;
    repeat (8) @(posedge pclk);
    presetn <= 1;
    repeat (2) @(posedge pclk);
    apb(0, `LSL_ADDR_HIGH, 0);
    chk(rd, 32'hFFF, "high reset");
    apb(1, 12'h018, 32'h5);
    chk(err, 1, "unmapped write");
    apb(0, 12'h018, 0);
    chk(err, 1, "unmapped");
    for (int i = 0; i < 6; i++) begin
      apb(1, `LSL_ADDR_LIDX, ix[i]);
      apb(1, `LSL_ADDR_LVAL, vx[i]);
      lut[ix[i] >> 2] = vx[i];
    end
    apb(1, `LSL_ADDR_LIDX, 12);
    apb(0, `LSL_ADDR_LVAL, 0);
    chk(rd, 30, "table readback");
    $display("register tests done");
    lo = 100;
    hi = 200;
    apb(1, `LSL_ADDR_LOW, lo);
    apb(1, `LSL_ADDR_HIGH, hi);
    set(5'h01);
    px = '{50, 300, 150, 4095, 100, 200};
    line(0);
    set(5'h1B);
    px = '{9, 4094, 8, 3, 4093, 4095, 0, 12};
    line(1);
    set(5'h15);
    px = '{4000, 10, 2048};
    line(0);
    apb(0, `LSL_ADDR_STAT, 0);
    chk(rd, 3, "line count");
    set(5'h00);
    lines = 0;
    apb(0, `LSL_ADDR_STAT, 0);
    chk(rd, 0, "count cleared");
    $display("counter tests done");
    px = '{7, 8};
    line(0);
    set(5'h01);
    px = '{1};
    line(0);
    conclude();
  end
endmodule // lsl_top_tb
`default_nettype wire
